//--- verilog/sie_irq_enable.sv
// Interrupt enable slice (bits 12..7) with AXI4-Lite slave and sticky event status
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
module sie_irq_enable (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    // Write data channel
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // Write response channel
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // Read address channel
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    // Read data channel
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Status flags from the command and data paths
    input wire sie_pkg::sie_flags_t flags,
    // Shared host interrupt request and summary interrupt
    output logic host_irq,
    output logic irq
);
    // ****************************************
    // Write channel
    // ****************************************
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic next_w_held;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic do_write;
    logic [5:0] enable;
    logic [5:0] status;
    logic [5:0] mask;
    logic [5:0] flags_q;
    logic [5:0] next_enable;
    logic [5:0] next_status;
    logic [5:0] next_mask;
    logic [5:0] wr_field;
    logic [5:0] events;

    // Address and data are accepted independently; both must be held before the write commits
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign do_write = aw_held && w_held && !bvalid;
    // Only byte lanes 0 and 1 carry fields, bits 12..7 span both
    assign wr_field = {(w_strb[1] ? w_data[12:8] : {enable[5:1]}), (w_strb[0] ? w_data[7] : enable[0])};

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (awvalid && awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_held = 1'b1;
            next_w_data = wdata;
            next_w_strb = wstrb;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (aw_addr == sie_pkg::ENABLE_OFFSET || aw_addr == sie_pkg::STATUS_OFFSET ||
                          aw_addr == sie_pkg::MASK_OFFSET || aw_addr == sie_pkg::PENDING_OFFSET)
                         ? sie_pkg::RESP_OKAY : sie_pkg::RESP_SLVERR;
        end else if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= sie_pkg::RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
        end
    end

    // ****************************************
    // Enable, sticky status and mask
    // ****************************************
    // Rising edges of the flags are the events; flags come from logic on this clock
    assign events = flags & ~flags_q;

    always_comb begin
        next_enable = enable;
        next_mask = mask;
        next_status = status;
        if (do_write && aw_addr == sie_pkg::ENABLE_OFFSET) begin
            next_enable = wr_field;
        end
        if (do_write && aw_addr == sie_pkg::MASK_OFFSET) begin
            next_mask = {(w_strb[1] ? w_data[12:8] : mask[5:1]), (w_strb[0] ? w_data[7] : mask[0])};
        end
        if (do_write && aw_addr == sie_pkg::STATUS_OFFSET) begin
            next_status = status & ~{(w_strb[1] ? w_data[12:8] : 5'h00), (w_strb[0] ? w_data[7] : 1'b0)};
        end
        // A new event wins over a clear in the same cycle
        next_status = next_status | events;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable <= sie_pkg::ENABLE_RESET;
            status <= sie_pkg::STATUS_RESET;
            mask <= sie_pkg::MASK_RESET;
            flags_q <= 6'h00;
        end else begin
            enable <= next_enable;
            status <= next_status;
            mask <= next_mask;
            flags_q <= flags;
        end
    end

    // ****************************************
    // Interrupt outputs
    // ****************************************
    logic next_host_irq;
    logic next_irq;

    // Registered so both requests are glitch free; costs one cycle of latency
    always_comb begin
        next_host_irq = |(flags & enable);
        next_irq = |(status & mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_irq <= 1'b0;
            irq <= 1'b0;
        end else begin
            host_irq <= next_host_irq;
            irq <= next_irq;
        end
    end

    // ****************************************
    // Read channel
    // ****************************************
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [5:0] rd_field;

    assign arready = !rvalid;

    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        rd_field = 6'h00;
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp = sie_pkg::RESP_OKAY;
            unique case (araddr)
                sie_pkg::ENABLE_OFFSET: rd_field = enable;
                sie_pkg::STATUS_OFFSET: rd_field = status;
                sie_pkg::MASK_OFFSET: rd_field = mask;
                sie_pkg::PENDING_OFFSET: rd_field = status & mask;
                default: next_rresp = sie_pkg::RESP_SLVERR;
            endcase
            // Reserved bits read as zero
            next_rdata = {19'h00000, rd_field, 7'h00};
        end else if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= sie_pkg::RESP_OKAY;
        end else begin
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end
endmodule : sie_irq_enable

//--- verilog/sie_pkg.sv
// Package: register map, field positions and bus types of the interrupt enable slice
package sie_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ENABLE_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] MASK_OFFSET = 8'h08;
    localparam logic [7:0] PENDING_OFFSET = 8'h0c;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int CMD_SENT_BIT = 7;
    localparam int TRANSFER_END_BIT = 8;
    localparam int STARTBIT_ERR_BIT = 9;
    localparam int BLOCK_END_BIT = 10;
    localparam int CMD_ACTIVE_BIT = 11;
    localparam int TX_ACTIVE_BIT = 12;
    localparam int FIELD_LSB = 7;
    localparam int FIELD_WIDTH = 6;
    localparam logic [5:0] ENABLE_RESET = 6'h00;
    localparam logic [5:0] STATUS_RESET = 6'h00;
    localparam logic [5:0] MASK_RESET = 6'h00;

    // ****************************************
    // Response codes
    // ****************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Status flags of the host, one per gated event
    typedef struct packed {
        logic tx_active;
        logic cmd_active;
        logic block_end;
        logic startbit_err;
        logic transfer_end;
        logic cmd_sent;
    } sie_flags_t;
endpackage : sie_pkg

//--- sim/sie_irq_enable_sva.sv
// Checker: handshake and interrupt gating properties of the enable slice
module sie_irq_enable_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    // Events and requests
    input wire sie_pkg::sie_flags_t flags,
    input wire logic host_irq,
    input wire logic irq
);
    // ****************************************
    // Properties
    // ****************************************
    logic wrote;
    logic next_wrote;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Until a write finishes every enable and mask is at reset, so no request may appear
    assign next_wrote = wrote | bvalid;
    always_ff @(posedge aclk) begin
        wrote <= aresetn ? next_wrote : 1'b0;
    end
    chk_reset_quiet: assert property (!wrote |-> !host_irq && !irq) else $error("request before any write");
    chk_host_gate: assert property (host_irq |-> $past(flags) != 6'h00) else $error("request without a flag");
    chk_flag_drop: assert property (flags == 6'h00 |=> !host_irq) else $error("request outlived flags");
    chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write answer dropped");
    chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read answer dropped");
    chk_read_answer: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
    chk_write_answer: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid) else $error("write answer late");
    chk_ar_block: assert property (rvalid |-> !arready) else $error("read taken while answer pending");
    cov_host: cover property (host_irq);
    cov_irq: cover property (irq);
    cov_slverr: cover property (bvalid && bresp == sie_pkg::RESP_SLVERR);
endmodule : sie_irq_enable_sva

bind sie_irq_enable sie_irq_enable_sva u_sva (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
    .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .flags, .host_irq, .irq);

//--- sim/sie_irq_enable_test.sv
// Testbench: register access, enable gating and status interrupt of the enable slice
module sie_irq_enable_test;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // Signals and design
    // ****************************************
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, host_irq, irq;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, r;
    sie_pkg::sie_flags_t flags = 6'h00;
    int mismatches = 0, checks = 0;
    sie_irq_enable u_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
        .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .flags, .host_irq, .irq);
    // 20 MHz clock
    always #25 aclk = ~aclk;
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Each half is released at its own handshake edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        r = bresp; bready <= 0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        d = rdata; r = rresp; rready <= 0;
        @(posedge aclk);
    endtask : rd
    task automatic t_reset;
        flags <= 6'h3f; repeat (2) @(posedge aclk);
        chk("host_irq reset", host_irq, 0);
        rd(sie_pkg::ENABLE_OFFSET); chk("enable reset", d, 0);
        rd(sie_pkg::MASK_OFFSET); chk("mask reset", d, 0);
        flags <= 6'h00;
    endtask : t_reset
    // One enable bit at a time: its own flag passes, all others stay blocked
    task automatic t_bits;
        for (int i = 0; i < 6; i++) begin
            wr(sie_pkg::ENABLE_OFFSET, 32'h1 << (sie_pkg::FIELD_LSB + i));
            rd(sie_pkg::ENABLE_OFFSET); chk("enable", d, 32'h1 << (sie_pkg::FIELD_LSB + i));
            flags <= sie_pkg::sie_flags_t'(6'h1 << i); repeat (2) @(posedge aclk);
            chk("host_irq on", host_irq, 1);
            flags <= sie_pkg::sie_flags_t'(~(6'h1 << i)); repeat (2) @(posedge aclk);
            chk("host_irq off", host_irq, 0);
            flags <= 6'h00;
        end
    endtask : t_bits
    // Reset in mid-run with an enable set: every enable falls back to disabled
    task automatic t_rerun;
        aresetn <= 0; repeat (2) @(posedge aclk);
        aresetn <= 1; @(posedge aclk);
        flags <= 6'h3f; repeat (2) @(posedge aclk);
        chk("host_irq rerun", host_irq, 0);
        rd(sie_pkg::ENABLE_OFFSET); chk("enable rerun", d, 0);
        flags <= 6'h00;
    endtask : t_rerun
    // Sticky status raised while masked, then unmasked, then cleared by writing one
    task automatic t_irq;
        wr(sie_pkg::STATUS_OFFSET, 32'h1f80);
        rd(sie_pkg::STATUS_OFFSET); chk("status cleared", d, 0);
        flags <= 6'h02; repeat (3) @(posedge aclk);
        chk("irq masked", irq, 0);
        flags <= 6'h00;
        rd(sie_pkg::STATUS_OFFSET); chk("status set", d, 32'h100);
        wr(sie_pkg::MASK_OFFSET, 32'h100);
        chk("irq unmasked", irq, 1);
        rd(sie_pkg::PENDING_OFFSET); chk("pending", d, 32'h100);
        wr(sie_pkg::STATUS_OFFSET, 32'h100); @(posedge aclk);
        chk("irq cleared", irq, 0);
        // Flag rises in the very cycle the clear commits: the new event must survive
        fork
            wr(sie_pkg::STATUS_OFFSET, 32'h100);
            begin
                @(posedge aclk);
                flags <= 6'h02;
            end
        join
        flags <= 6'h00;
        rd(sie_pkg::STATUS_OFFSET); chk("set over clear", d, 32'h100);
        // Pending view ignores writes but answers them
        wr(sie_pkg::PENDING_OFFSET, 32'h0); chk("bresp pending", r, sie_pkg::RESP_OKAY);
        rd(sie_pkg::PENDING_OFFSET); chk("pending kept", d, 32'h100);
    endtask : t_irq
    task automatic t_unmapped;
        wr(8'h10, 32'hffff_ffff); chk("bresp unmapped", r, sie_pkg::RESP_SLVERR);
        rd(8'h10); chk("rresp unmapped", r, sie_pkg::RESP_SLVERR);
        chk("rdata unmapped", d, 0);
    endtask : t_unmapped
    task automatic close_out;
        if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    // ****************************************
    // Sequence and watchdog
    // ****************************************
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset;
        t_bits;
        t_rerun;
        t_irq;
        t_unmapped;
        close_out;
    end
    // The run needs under two hundred cycles; a stuck handshake ends here
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        close_out;
    end
endmodule : sie_irq_enable_test
